// file: common/aic_pkg.sv
/*
  Constants, types and helpers for the analog input conditioning block.
  Assumes 16-bit signed converter codes where 0.01 % of 10 V is one count.
*/
package aic_pkg;
  // ****************************************
  // Scaling
  // ****************************************
  localparam int NCH        = 32'h0000_0004;
  localparam int FS         = 32'h0000_2710;  // 10 V, 100.00 %
  localparam int LIVE_ZERO  = 32'h0000_07D0;  // 4 mA on a 20 mA span
  localparam int LZ_MUL     = 32'h0000_0005;  // 4 * FS / (FS - LIVE_ZERO)
  localparam int LZ_SH      = 32'h0000_0002;
  localparam int GAIN_ONE   = 32'h0000_03E8;
  localparam int GAIN_MAX   = 32'h0000_270F;
  localparam int OFS_MAX    = 32'h0000_2710;
  localparam int TC_MAX     = 32'h0000_0640;  // 16.00 s in 10 ms steps
  localparam int TC_UNIT_US = 32'h0000_2710;
  localparam int TQ_MUL     = 32'h0000_0002;  // 10 V gives 200 %
  localparam int TQ_MAX     = 32'h0000_4E20;
  localparam int FRAC       = 32'h0000_000C;
  localparam int COEF_SH    = 32'h0000_0010;
  localparam logic [16:0] COEF_ONE = 17'h1_0000;
  localparam logic [4:0]  DIV_LAST = 5'h1F;
  localparam logic [1:0]  CH_NO_PTC = 2'h3;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] A_CTRL  = 8'h00;
  localparam logic [7:0] A_MINSP = 8'h04;
  localparam logic [7:0] A_MAXSP = 8'h08;
  localparam logic [7:0] A_FWDTQ = 8'h0C;
  localparam logic [7:0] A_REVTQ = 8'h10;
  localparam logic [7:0] A_RATED = 8'h14;
  localparam logic [7:0] A_PIDFB = 8'h18;
  localparam logic [7:0] A_STAT  = 8'h90;
  localparam logic [1:0] CH_SEL  = 2'h1;   // 0x40 + 0x10 * channel
  localparam logic [3:0] MON_NIB = 4'h8;   // 0x80 + 4 * channel
  localparam logic [1:0] F_CFG   = 2'h0;
  localparam logic [1:0] F_GAIN  = 2'h1;
  localparam logic [1:0] F_OFS   = 2'h2;
  localparam logic [1:0] F_TC    = 2'h3;
  localparam int CFG_TYPE_LSB    = 32'h0000_0004;
  localparam logic [13:0] RST_GAIN  = 14'h03E8;
  localparam logic [15:0] RST_MAXSP = 16'h03E8;
  localparam logic [15:0] RST_TQ    = 16'h2710;
  localparam logic [15:0] RST_RATED = 16'h0064;

  typedef enum logic [2:0] {
    FN_SPEED = 3'h0, FN_NORAMP = 3'h1, FN_TORQUE = 3'h2, FN_PV = 3'h3,
    FN_PTC = 3'h4, FN_UNUSED5 = 3'h5, FN_UNUSED6 = 3'h6, FN_PLC = 3'h7
  } aic_func_t;

  typedef enum logic [2:0] {
    ST_UNI = 3'h0, ST_LIVE = 3'h1, ST_INV = 3'h2, ST_INV_LIVE = 3'h3,
    ST_BIPOLAR = 3'h4
  } aic_stype_t;

  function automatic logic signed [31:0] sat(
      input logic signed [31:0] x,
      input logic signed [31:0] lo,
      input logic signed [31:0] hi);
    sat = (x < lo) ? lo : ((x > hi) ? hi : x);
  endfunction

  // Fourth input has no PTC path
  function automatic aic_func_t eff_func(input logic [1:0] ch,
                                         input logic [2:0] f);
    if (ch == CH_NO_PTC && f == FN_PTC)
      eff_func = FN_UNUSED5;
    else
      eff_func = aic_func_t'(f);
  endfunction
endpackage

// file: common/aic_if.sv
/*
  Carriers between the top and its conditioning and divider modules.
  Assumes one clock domain; no clocking blocks.
*/
interface aic_cond_if;
  logic signed [15:0] raw;
  logic        [2:0]  stype;
  logic               bip_ok;
  logic signed [15:0] ofs;
  logic        [13:0] gain;
  logic signed [15:0] value;
  modport mst (output raw, stype, bip_ok, ofs, gain, input value);
  modport slv (input raw, stype, bip_ok, ofs, gain, output value);
endinterface

interface aic_div_if;
  logic        start;
  logic [31:0] den;
  logic        busy;
  logic        done;
  logic [16:0] quot;
  modport mst (output start, den, input busy, done, quot);
  modport slv (input start, den, output busy, done, quot);
endinterface

// file: verilog/aic_cond.sv
/*
  Combinational range decode, offset, gain and clamp of one sample.
  Assumes the caller registers the result.
*/
module aic_cond import aic_pkg::*; (
  aic_cond_if.slv c
);
  logic signed [31:0] s;
  logic signed [31:0] ls;
  logic signed [31:0] u;
  logic signed [31:0] p;

  always_comb begin
    s  = 32'(c.raw);
    ls = ((s - LIVE_ZERO) * LZ_MUL) >>> LZ_SH;
    case (c.stype)
      ST_LIVE:     u = sat(ls, 0, FS); // RL15
      ST_INV:      u = FS - sat(s, 0, FS); // RL17
      ST_INV_LIVE: u = FS - sat(ls, 0, FS); // RL17
      ST_BIPOLAR:  u = c.bip_ok ? sat(s, -FS, FS) : sat(s, 0, FS); // RL16
      default:     u = sat(s, 0, FS); // RL15
    endcase
    // Worst case 20000 * 9999 stays well inside 32 bits
    p = ((u + 32'(c.ofs)) * 32'($signed({1'b0, c.gain}))) / GAIN_ONE; // RL9
    c.value = 16'(sat(p, -FS, FS)); // RL21
  end
endmodule

// file: verilog/aic_div.sv
/*
  Sequential restoring divider for the smoother coefficient.
  Assumes start is only raised while busy is low.
*/
module aic_div import aic_pkg::*; #(
  parameter int unsigned NUM = 32'h03E8_0000
) (
  input wire logic hclk,
  input wire logic hresetn,
  aic_div_if.slv   d
);
  typedef enum logic [1:0] {DV_IDLE = 2'b01, DV_RUN = 2'b10} aic_dv_st_t;

  if (NUM == 0) $error("aic_div: NUM must be nonzero");

  aic_dv_st_t  state_ff;
  logic [32:0] rem_ff;
  logic [31:0] q_ff;
  logic [31:0] den_ff;
  logic [4:0]  cnt_ff;
  logic        done_ff;
  logic [32:0] r2;
  logic        ge;

  always_comb begin
    r2 = {rem_ff[31:0], q_ff[31]};
    ge = r2 >= {1'b0, den_ff};
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff <= DV_IDLE;
      rem_ff   <= '0;
      q_ff     <= '0;
      den_ff   <= '0;
      cnt_ff   <= '0;
      done_ff  <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      case (state_ff)
        DV_IDLE: if (d.start) begin
          rem_ff   <= '0;
          q_ff     <= NUM;
          den_ff   <= d.den;
          cnt_ff   <= DIV_LAST;
          state_ff <= DV_RUN;
        end
        DV_RUN: begin
          rem_ff <= ge ? r2 - {1'b0, den_ff} : r2;
          q_ff   <= {q_ff[30:0], ge};
          cnt_ff <= cnt_ff - 5'h1;
          if (cnt_ff == '0) begin
            done_ff  <= 1'b1;
            state_ff <= DV_IDLE;
          end
        end
        default: state_ff <= DV_IDLE;
      endcase
    end
  end

  assign d.busy = (state_ff != DV_IDLE);
  assign d.done = done_ff;
  assign d.quot = q_ff[16:0];
endmodule

// file: verilog/aic_top.sv
/*
  Analog input conditioning and function routing for four inputs,
  with an AHB-Lite register slave. Assumes one converter sample per
  adc_valid, tagged with its channel, and one master on the bus.
*/
// The implementer's own choices: register access over AHB-Lite and the placing of the registers.
// Function
// RL1: Selector codes pick speed, unramped, torque, PV, PTC, unused or PLC.
// RL2: Fourth input treats PTC code as unused.
// RL3: Speed reference is scaled, bounded by min and max speed, ramped.
// RL4: Unramped reference bypasses ramp, only in vector mode.
// RL5: Torque code sets both limits; fixed limits then ignored.
// RL6: Torque limit spans 0 to 200 %; full scale gives 200 %.
// RL7: Process variable feeds PID feedback one to one.
// RL8: PLC code forwards the conditioned value to the option board.
// RL9: Value is raw plus offset share of 10 V, times gain.
// RL10: Gain accepts 0.000 to 9.999.
// RL11: Offset accepts -100.00 to 100.00 %, resets to zero.
// RL12: Negative speed value commands reverse with its magnitude.
// RL13: Negative torque value clamps to zero.
// RL14: Filter time constant 0.00 to 16.00 s; zero means no filtering.
// RL15: Inputs one and three decode signal types 0 to 3.
// RL16: Inputs two and four also accept bipolar type 4.
// RL17: Types 2 and 3 invert the scaling.
// RL18: Each input has a read-only monitor, torque percent when selected.
// RL19: Monitor shows percent after offset and gain, -100 to 100.
// RL20: Filter is an exponential smoother with a derived coefficient.
// RL21: Arithmetic wide enough to avoid overflow before clamping.
module aic_top import aic_pkg::*; #(
  parameter int SAMPLE_US = 32'h0000_03E8
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic               adc_valid,
  input  wire logic [1:0]         adc_chan,
  input  wire logic signed [15:0] adc_data,
  output logic [15:0]             speed_ref,
  output logic                    speed_rev,
  output logic                    speed_vld,
  output logic signed [15:0]      noramp_ref,
  output logic                    noramp_vld,
  output logic [15:0]             fwd_tq_lim,
  output logic [15:0]             rev_tq_lim,
  output logic signed [15:0]      pid_fb,
  output logic                    pid_vld,
  output logic signed [15:0]      ptc_level,
  output logic                    ptc_vld,
  output logic signed [15:0]      plc_data,
  output logic [1:0]              plc_chan,
  output logic                    plc_vld
);
  if (SAMPLE_US < 1 || SAMPLE_US > 32'h0000_7FFF)
    $error("aic_top: SAMPLE_US out of range");

  // ****************************************
  // Bus slave
  // ****************************************
  logic               ap_vld_ff, ap_wr_ff, ap_hit_ff, hready_ff;
  logic [7:0]         ap_addr_ff;
  logic [31:0]        hrdata_ff, rd_mux;
  logic               acc, wr, isch;
  logic [1:0]         wch, fld;
  logic               vec_mode_ff;
  logic [15:0]        min_spd_ff, max_spd_ff, fwd_fix_ff, rev_fix_ff;
  logic [15:0]        rated_ff;
  logic [2:0]         pid_sel_ff;
  logic [2:0]         func_ff  [NCH];
  logic [2:0]         type_ff  [NCH];
  logic [13:0]        gain_ff  [NCH];
  logic signed [15:0] ofs_ff   [NCH];
  logic [10:0]        tc_ff    [NCH];
  logic signed [15:0] mon_ff   [NCH];
  logic [16:0]        coef_ff  [NCH];
  logic signed [31:0] acc_ff   [NCH];
  logic [NCH-1:0]     dirty_ff, wr_tc;

  assign acc = hsel && htrans[1] && hready;
  assign wr  = ap_vld_ff && ap_wr_ff && ap_hit_ff;
  assign isch = (ap_addr_ff[7:6] == CH_SEL);
  assign wch = ap_addr_ff[5:4];
  assign fld = ap_addr_ff[3:2];

  // Reads take one wait state so a write just before is always seen
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_vld_ff  <= 1'b0;
      ap_wr_ff   <= 1'b0;
      ap_hit_ff  <= 1'b0;
      ap_addr_ff <= '0;
      hready_ff  <= 1'b1;
      hrdata_ff  <= '0;
    end else begin
      ap_vld_ff <= acc;
      if (acc) begin
        ap_wr_ff   <= hwrite;
        ap_hit_ff  <= (haddr[31:8] == '0) && (hsize == 3'h2);
        ap_addr_ff <= haddr[7:0];
      end
      hready_ff <= !(acc && !hwrite);
      if (ap_vld_ff && !ap_wr_ff)
        hrdata_ff <= rd_mux;
    end
  end

  always_comb begin
    rd_mux = '0;
    if (ap_hit_ff) begin
      case (ap_addr_ff)
        A_CTRL:  rd_mux[0] = vec_mode_ff;
        A_MINSP: rd_mux[15:0] = min_spd_ff;
        A_MAXSP: rd_mux[15:0] = max_spd_ff;
        A_FWDTQ: rd_mux[15:0] = fwd_fix_ff;
        A_REVTQ: rd_mux[15:0] = rev_fix_ff;
        A_RATED: rd_mux[15:0] = rated_ff;
        A_PIDFB: rd_mux[2:0] = pid_sel_ff;
        A_STAT:  rd_mux[NCH-1:0] = dirty_ff;
        default: begin
          if (isch) begin
            case (fld)
              F_CFG: begin
                rd_mux[2:0] = func_ff[wch];
                rd_mux[CFG_TYPE_LSB+:3] = type_ff[wch];
              end
              F_GAIN:  rd_mux[13:0] = gain_ff[wch];
              F_OFS:   rd_mux[15:0] = ofs_ff[wch];
              default: rd_mux[10:0] = tc_ff[wch];
            endcase
          end else if (ap_addr_ff[7:4] == MON_NIB) begin
            rd_mux[15:0] = mon_ff[fld]; // RL18
          end
        end
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < NCH; i++)
      wr_tc[i] = wr && isch && fld == F_TC && wch == 2'(i);
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  // Out-of-range writes saturate rather than wrap
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      vec_mode_ff <= 1'b0;
      min_spd_ff  <= '0;
      max_spd_ff  <= RST_MAXSP;
      fwd_fix_ff  <= RST_TQ;
      rev_fix_ff  <= RST_TQ;
      rated_ff    <= RST_RATED;
      pid_sel_ff  <= '0;
      for (int i = 0; i < NCH; i++) begin
        func_ff[i] <= '0;
        type_ff[i] <= '0;
        gain_ff[i] <= RST_GAIN;
        ofs_ff[i]  <= '0; // RL11
        tc_ff[i]   <= '0;
      end
    end else if (wr) begin
      case (ap_addr_ff)
        A_CTRL:  vec_mode_ff <= hwdata[0];
        A_MINSP: min_spd_ff <= hwdata[15:0];
        A_MAXSP: max_spd_ff <= hwdata[15:0];
        A_FWDTQ: fwd_fix_ff <= hwdata[15:0];
        A_REVTQ: rev_fix_ff <= hwdata[15:0];
        A_RATED: rated_ff <= hwdata[15:0];
        A_PIDFB: pid_sel_ff <= hwdata[2:0];
        default: begin
          if (isch) begin
            case (fld)
              F_CFG: begin
                func_ff[wch] <= hwdata[2:0]; // RL1
                type_ff[wch] <= hwdata[CFG_TYPE_LSB+:3];
              end
              F_GAIN: gain_ff[wch] <= (hwdata > GAIN_MAX) ?
                  14'(GAIN_MAX) : hwdata[13:0]; // RL10
              F_OFS: ofs_ff[wch] <= 16'(sat(32'($signed(hwdata[15:0])),
                  -OFS_MAX, OFS_MAX)); // RL11
              default: tc_ff[wch] <= (hwdata > TC_MAX) ?
                  11'(TC_MAX) : hwdata[10:0]; // RL14
            endcase
          end
        end
      endcase
    end
  end

  // ****************************************
  // Coefficient scheduler
  // ****************************************
  aic_div_if dv ();
  logic       start_ff;
  logic [1:0] div_ch_ff, pick;

  aic_div #(.NUM(32'(SAMPLE_US) << COEF_SH)) u_div (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       (dv)
  );

  always_comb begin
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--)
      if (dirty_ff[i]) pick = 2'(i);
  end

  assign dv.start = start_ff;
  assign dv.den = 32'(tc_ff[div_ch_ff]) * 32'(TC_UNIT_US) + 32'(SAMPLE_US);

  // A new write during a division marks the channel again: set wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dirty_ff  <= '0;
      start_ff  <= 1'b0;
      div_ch_ff <= '0;
      for (int i = 0; i < NCH; i++)
        coef_ff[i] <= COEF_ONE; // RL14
    end else begin
      start_ff <= 1'b0;
      if (!start_ff && !dv.busy && |dirty_ff) begin
        start_ff  <= 1'b1;
        div_ch_ff <= pick;
      end
      for (int i = 0; i < NCH; i++)
        if (wr_tc[i])
          dirty_ff[i] <= 1'b1;
        else if (!start_ff && !dv.busy && pick == 2'(i))
          dirty_ff[i] <= 1'b0;
      if (dv.done)
        coef_ff[div_ch_ff] <= dv.quot; // RL20
    end
  end

  // ****************************************
  // Sample pipeline
  // ****************************************
  aic_cond_if cd ();
  logic               a_vld_ff, b_vld_ff;
  logic [1:0]         a_ch_ff, b_ch_ff;
  logic signed [15:0] a_raw_ff, y, ymag;
  logic signed [31:0] e;
  logic signed [47:0] prod;
  aic_func_t          af, bf;
  logic [31:0]        rpm;
  logic [15:0]        tq;
  logic               tq_any;

  aic_cond u_cond (
    .c (cd)
  );

  assign cd.raw    = a_raw_ff;
  assign cd.stype  = type_ff[a_ch_ff];
  assign cd.bip_ok = a_ch_ff[0]; // RL16
  assign cd.ofs    = ofs_ff[a_ch_ff];
  assign cd.gain   = gain_ff[a_ch_ff];

  always_comb begin
    af   = eff_func(a_ch_ff, func_ff[a_ch_ff]); // RL2
    bf   = eff_func(b_ch_ff, func_ff[b_ch_ff]);
    e    = (32'(cd.value) <<< FRAC) - acc_ff[a_ch_ff];
    prod = 48'(e) * 48'($signed({1'b0, coef_ff[a_ch_ff]})); // RL20
    y    = 16'(acc_ff[b_ch_ff] >>> FRAC);
    ymag = (y < 0) ? -y : y; // RL12
    rpm  = (32'(ymag) * 32'(max_spd_ff)) / FS;
    tq   = 16'(sat(32'(y), 0, FS) * TQ_MUL); // RL13
    tq_any = 1'b0;
    for (int i = 0; i < NCH; i++)
      if (eff_func(2'(i), func_ff[i]) == FN_TORQUE) tq_any = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_vld_ff <= 1'b0;
      b_vld_ff <= 1'b0;
      a_ch_ff  <= '0;
      b_ch_ff  <= '0;
      a_raw_ff <= '0;
      for (int i = 0; i < NCH; i++) begin
        mon_ff[i] <= '0;
        acc_ff[i] <= '0;
      end
    end else begin
      a_vld_ff <= adc_valid;
      b_vld_ff <= a_vld_ff;
      b_ch_ff  <= a_ch_ff;
      if (adc_valid) begin
        a_ch_ff  <= adc_chan;
        a_raw_ff <= adc_data;
      end
      if (a_vld_ff) begin
        mon_ff[a_ch_ff] <= (af == FN_TORQUE) ?
            16'(sat(32'(cd.value), 0, FS) * TQ_MUL) : cd.value; // RL18 RL19
        acc_ff[a_ch_ff] <= acc_ff[a_ch_ff] + 32'(prod >>> COEF_SH);
      end
    end
  end

  // ****************************************
  // Function routing
  // ****************************************
  logic [15:0]        speed_ff, fwd_ff, rev_ff;
  logic               srev_ff, svld_ff, nvld_ff, pvld_ff, tvld_ff, lvld_ff;
  logic signed [15:0] nref_ff, pid_ff, ptc_ff, plc_ff;
  logic [1:0]         plc_ch_ff;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      speed_ff <= '0;
      srev_ff  <= 1'b0;
      svld_ff  <= 1'b0;
      nref_ff  <= '0;
      nvld_ff  <= 1'b0;
      fwd_ff   <= RST_TQ;
      rev_ff   <= RST_TQ;
      pid_ff   <= '0;
      pvld_ff  <= 1'b0;
      ptc_ff   <= '0;
      tvld_ff  <= 1'b0;
      plc_ff   <= '0;
      plc_ch_ff <= '0;
      lvld_ff  <= 1'b0;
    end else begin
      svld_ff <= 1'b0;
      nvld_ff <= 1'b0;
      pvld_ff <= 1'b0;
      tvld_ff <= 1'b0;
      lvld_ff <= 1'b0;
      if (!tq_any) begin
        fwd_ff <= fwd_fix_ff;
        rev_ff <= rev_fix_ff;
      end
      if (b_vld_ff) begin
        case (bf)
          FN_SPEED: begin
            speed_ff <= 16'(sat(rpm, 32'(min_spd_ff),
                32'(max_spd_ff))); // RL3
            srev_ff  <= (y < 0); // RL12
            svld_ff  <= 1'b1;
          end
          FN_NORAMP: if (vec_mode_ff) begin
            nref_ff <= y; // RL4
            nvld_ff <= 1'b1;
          end
          FN_TORQUE: begin
            fwd_ff <= tq; // RL5
            rev_ff <= tq; // RL6
          end
          FN_PV: if (pid_sel_ff == {1'b0, b_ch_ff} + 3'h1) begin
            pid_ff  <= y; // RL7
            pvld_ff <= 1'b1;
          end
          FN_PTC: begin
            ptc_ff  <= y;
            tvld_ff <= 1'b1;
          end
          FN_PLC: begin
            plc_ff    <= y; // RL8
            plc_ch_ff <= b_ch_ff;
            lvld_ff   <= 1'b1;
          end
          default: ;
        endcase
      end
    end
  end

  assign hrdata     = hrdata_ff;
  assign hreadyout  = hready_ff;
  assign hresp      = 1'b0;
  assign speed_ref  = speed_ff;
  assign speed_rev  = srev_ff;
  assign speed_vld  = svld_ff;
  assign noramp_ref = nref_ff;
  assign noramp_vld = nvld_ff;
  assign fwd_tq_lim = fwd_ff;
  assign rev_tq_lim = rev_ff;
  assign pid_fb     = pid_ff;
  assign pid_vld    = pvld_ff;
  assign ptc_level  = ptc_ff;
  assign ptc_vld    = tvld_ff;
  assign plc_data   = plc_ff;
  assign plc_chan   = plc_ch_ff;
  assign plc_vld    = lvld_ff;

  // ****************************************
  // Checks
  // ****************************************
  logic gain_ok, ofs_ok, tc_ok, mon_ok;
  always_comb begin
    gain_ok = 1'b1;
    ofs_ok  = 1'b1;
    tc_ok   = 1'b1;
    mon_ok  = 1'b1;
    for (int i = 0; i < NCH; i++) begin
      gain_ok &= (gain_ff[i] <= GAIN_MAX);
      ofs_ok  &= (ofs_ff[i] <= OFS_MAX) && (ofs_ff[i] >= -OFS_MAX);
      tc_ok   &= (tc_ff[i] <= TC_MAX);
      mon_ok  &= (mon_ff[i] >= -FS) && (mon_ff[i] <= TQ_MAX);
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_noramp; nvld_ff |-> $past(vec_mode_ff); endproperty
  property p_spd;
    svld_ff && $past(min_spd_ff <= max_spd_ff) |->
      speed_ff >= $past(min_spd_ff) && speed_ff <= $past(max_spd_ff);
  endproperty
  property p_tqfix; !tq_any |=> fwd_ff == $past(fwd_fix_ff); endproperty
  property p_tqrng;
    $past(b_vld_ff && bf == FN_TORQUE) |-> fwd_ff == rev_ff && fwd_ff <= TQ_MAX;
  endproperty
  property p_tqneg;
    $past(b_vld_ff && bf == FN_TORQUE && y < 0) |-> fwd_ff == '0;
  endproperty
  property p_ptc; tvld_ff |-> $past(b_ch_ff) != CH_NO_PTC; endproperty
  property p_pid;
    pvld_ff |-> pid_ff == $past(y) && $past(pid_sel_ff) != '0;
  endproperty
  property p_plc; lvld_ff |-> plc_ff == $past(y) && plc_ch_ff == $past(b_ch_ff);
  endproperty
  property p_rev; svld_ff |-> srev_ff == $past(y < 0); endproperty
  property p_gain; gain_ok; endproperty
  property p_ofs; ofs_ok; endproperty
  property p_tc; tc_ok; endproperty
  property p_mon; mon_ok; endproperty
  property p_div; start_ff |-> ##[1:40] dv.done; endproperty

  a_noramp: assert property (p_noramp) else $error("unramped w/o vector"); // RL4
  a_spd: assert property (p_spd) else $error("speed out of limits"); // RL3
  a_tqfix: assert property (p_tqfix) else $error("fixed limit lost"); // RL5
  a_tqrng: assert property (p_tqrng) else $error("torque limit bad"); // RL6
  a_tqneg: assert property (p_tqneg) else $error("negative torque"); // RL13
  a_ptc: assert property (p_ptc) else $error("PTC on input four"); // RL2
  a_pid: assert property (p_pid) else $error("PID feedback wrong"); // RL7
  a_plc: assert property (p_plc) else $error("PLC value wrong"); // RL8
  a_rev: assert property (p_rev) else $error("direction wrong"); // RL12
  a_gain: assert property (p_gain) else $error("gain range"); // RL10
  a_ofs: assert property (p_ofs) else $error("offset range"); // RL11
  a_tc: assert property (p_tc) else $error("filter range"); // RL14
  a_mon: assert property (p_mon) else $error("monitor range"); // RL19
  a_div: assert property (p_div) else $error("divider stuck"); // RL20

  c_rev: cover property (svld_ff && srev_ff);
  c_tq: cover property ($past(b_vld_ff && bf == FN_TORQUE));
  c_plc: cover property (lvld_ff);
  c_div: cover property (dv.done);
endmodule

// file: testbench/aic_adc.sv
/* Converter front end model: one sample strobe per send call.
   Assumes calls start just after a rising hclk edge. */
module aic_adc (
  input  wire logic         hclk,
  output logic              adc_valid,
  output logic [1:0]        adc_chan,
  output logic [15:0]       adc_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial adc_valid = 1'b0;
  initial adc_chan = 2'h0;
  initial adc_data = 16'h0000;
  task automatic send(input logic [1:0] c, input logic [15:0] d);
    adc_valid <= 1'b1;
    adc_chan <= c;
    adc_data <= d;
    @(posedge hclk);
    adc_valid <= 1'b0;
    // Data not held after the strobe, so a stale read shows
    adc_data <= ~d;
  endtask
endmodule

// file: testbench/aic_top_bench.sv
/* Self-checking bench for aic_top over AHB-Lite and the sample stream.
   Assumes the converter model aic_adc on the sample inputs. */
module aic_top_bench import aic_pkg::*; ;
  timeunit 1ns;
  timeprecision 1ps;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h0;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, q;
  logic        hreadyout, hresp, adc_valid, speed_rev, speed_vld;
  logic        noramp_vld, pid_vld, ptc_vld, plc_vld;
  logic [1:0]  adc_chan, plc_chan;
  logic [15:0] adc_data, speed_ref, noramp_ref, fwd_tq_lim, rev_tq_lim;
  logic [15:0] pid_fb, ptc_level, plc_data;
  logic [15:0] tt [4][3] = '{'{16'h0001, 16'h1770, 16'h1388},
    '{16'h0002, 16'h0BB8, 16'h1B58}, '{16'h0003, 16'h0FA0, 16'h1D4C},
    '{16'h0000, 16'h09C4, 16'h09C4}};
  int          err_count = 0, cmp_count = 0, npl = 0, n0;
  aic_top aic_top_i (.hready(hreadyout), .*);
  aic_adc aic_adc_i (.*);
  initial forever #12.5 hclk = ~hclk;
  always @(posedge hclk) if (hresetn) npl <= npl + speed_vld + noramp_vld
      + pid_vld + ptc_vld + plc_vld;
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    hsize <= 3'h2;
    haddr <= 32'(a);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, e);
    end
  endtask
  task automatic wc(input logic [1:0] c, input logic [1:0] f,
                    input logic [31:0] d);
    bus(1'b1, {CH_SEL, c, f, 2'h0}, d, q);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000, q);
    chk(q, e);
  endtask
  // Output pulse lands three edges after the strobe; five leaves margin
  task automatic smp(input logic [1:0] c, input logic [15:0] d);
    aic_adc_i.send(c, d);
    repeat (5) @(posedge hclk);
  endtask
  task automatic results();
    $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #500_000;
    err_count++;
    results();
  end
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rc({CH_SEL, 2'h0, F_GAIN, 2'h0}, 32'h0000_03E8);
    rc({CH_SEL, 2'h0, F_OFS, 2'h0}, 32'h0000_0000);
    rc(8'hF0, 32'h0000_0000);
    chk(hresp, 32'h0000_0000);
    chk(fwd_tq_lim, 32'h0000_2710);
    wc(2'h1, F_GAIN, 32'h0000_FFFF);
    rc({CH_SEL, 2'h1, F_GAIN, 2'h0}, 32'h0000_270F);
    wc(2'h1, F_TC, 32'h0000_07D0);
    rc({CH_SEL, 2'h1, F_TC, 2'h0}, 32'h0000_0640);
    wc(2'h1, F_TC, 32'h0000_0000);
    wc(2'h1, F_GAIN, 32'h0000_03E8);
    wc(2'h0, F_OFS, 32'h0000_B1E0);
    rc({CH_SEL, 2'h0, F_OFS, 2'h0}, 32'h0000_D8F0);
    repeat (60) @(posedge hclk);
    rc(A_STAT, 32'h0000_0000);
    $display("test 1 done");
    wc(2'h0, F_OFS, 32'h0000_E4A8);
    wc(2'h0, F_GAIN, 32'h0000_07D0);
    wc(2'h0, F_CFG, 32'h0000_0007);
    smp(2'h0, 16'h1388);
    rc({MON_NIB, 2'h0, 2'h0}, 32'h0000_F060);
    chk(plc_data, 32'h0000_F060);
    chk(plc_chan, 32'h0000_0000);
    chk(npl, 32'h0000_0001);
    bus(1'b1, A_MINSP, 32'h0000_01F4, q);
    wc(2'h0, F_CFG, 32'h0000_0000);
    smp(2'h0, 16'h1388);
    chk(speed_ref, 32'h0000_01F4);
    chk(speed_rev, 32'h0000_0001);
    chk(npl, 32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      wc(2'h2, F_CFG, {25'h000_0000, tt[i][0][2:0], 4'h7});
      smp(2'h2, tt[i][1]);
      chk(plc_data, tt[i][2]);
    end
    $display("test 2 done");
    wc(2'h1, F_CFG, 32'h0000_0047);
    smp(2'h1, 16'hEC78);
    chk(plc_data, 32'h0000_EC78);
    bus(1'b1, A_FWDTQ, 32'h0000_1388, q);
    wc(2'h1, F_CFG, 32'h0000_0042);
    smp(2'h1, 16'h2710);
    chk(fwd_tq_lim, 32'h0000_4E20);
    chk(rev_tq_lim, 32'h0000_4E20);
    rc({MON_NIB, 2'h1, 2'h0}, 32'h0000_4E20);
    smp(2'h1, 16'hF448);
    chk(fwd_tq_lim, 32'h0000_0000);
    wc(2'h1, F_CFG, 32'h0000_0045);
    repeat (3) @(posedge hclk);
    chk(fwd_tq_lim, 32'h0000_1388);
    $display("test 3 done");
    wc(2'h0, F_OFS, 32'h0000_0000);
    wc(2'h0, F_GAIN, 32'h0000_03E8);
    n0 = npl;
    wc(2'h3, F_CFG, 32'h0000_0004);
    smp(2'h3, 16'h2710);
    wc(2'h0, F_CFG, 32'h0000_0001);
    smp(2'h0, 16'h2710);
    wc(2'h0, F_CFG, 32'h0000_0006);
    smp(2'h0, 16'h2710);
    chk(npl - n0, 32'h0000_0000);
    bus(1'b1, A_CTRL, 32'h0000_0001, q);
    wc(2'h0, F_CFG, 32'h0000_0001);
    smp(2'h0, 16'h2710);
    chk(noramp_ref, 32'h0000_2710);
    bus(1'b1, A_PIDFB, 32'h0000_0001, q);
    wc(2'h0, F_CFG, 32'h0000_0003);
    smp(2'h0, 16'h2710);
    chk(pid_fb, 32'h0000_2710);
    wc(2'h0, F_CFG, 32'h0000_0004);
    smp(2'h0, 16'h2710);
    chk(ptc_level, 32'h0000_2710);
    chk(npl - n0, 32'h0000_0003);
    $display("test 4 done");
    results();
  end
endmodule
